// ---- shared/ext_irq_pkg.sv ----
// Constants, register map and encodings of the external pin interrupt unit.
package ext_irq_pkg;

  // Core clock period and the timing figures derived from it.
  localparam int unsigned CLK_PERIOD_NS    = 8;
  localparam int unsigned WDT_PERIOD_NS    = 1000;
  localparam int unsigned WDT_TICK_CYCLES  = WDT_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned MIN_PULSE_NS     = 50;
  localparam int unsigned MIN_PULSE_CYCLES =
    (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STARTUP_CYCLES_DEF = 1024;
  localparam int unsigned STARTUP_CNT_W      = 16;
  localparam int unsigned WDT_CNT_W          = 8;

  localparam int unsigned NUM_PINS   = 8;
  localparam int unsigned NUM_LOWER  = 4;
  localparam int unsigned ADDR_W     = 3;
  localparam int unsigned DATA_W     = 8;

  // Register offsets.
  localparam logic [ADDR_W-1:0] LOWER_SENSE_OFS = 3'h0;
  localparam logic [ADDR_W-1:0] UPPER_SENSE_OFS = 3'h1;
  localparam logic [ADDR_W-1:0] MASK_OFS        = 3'h2;
  localparam logic [ADDR_W-1:0] FLAGS_OFS       = 3'h3;
  localparam logic [ADDR_W-1:0] GIE_OFS         = 3'h4;
  localparam logic [ADDR_W-1:0] PIN_LEVEL_OFS   = 3'h5;
  localparam logic [ADDR_W-1:0] WAKE_STAT_OFS   = 3'h6;

  // Field positions and reset values.
  localparam int unsigned GIE_BIT  = 0;
  localparam int unsigned WAKE_BIT = 0;
  localparam logic [DATA_W-1:0] LOWER_SENSE_RST = 8'h00;
  localparam logic [DATA_W-1:0] UPPER_SENSE_RST = 8'h00;
  localparam logic [DATA_W-1:0] MASK_RST        = 8'h00;
  localparam logic [DATA_W-1:0] FLAGS_RST       = 8'h00;
  localparam logic              GIE_RST         = 1'b0;

  // Two-bit sense select codes; code 1 is reserved on the lower pins.
  localparam logic [1:0] SENSE_LOW  = 2'h0;
  localparam logic [1:0] SENSE_ANY  = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;

endpackage

// ---- shared/wake_if.sv ----
// Signals between the interrupt core and its power-down wake sampler.
`timescale 1ns/100ps
interface wake_if;
  logic pd;
  logic lvl_low;
  logic wake;
  logic busy;

  modport core  (output pd, output lvl_low, input wake, input busy);
  modport waker (input pd, input lvl_low, output wake, output busy);
endinterface

// ---- logic/pd_wake_sampler.sv ----
// Samples a wake level twice on the watchdog tick and runs the start-up delay.
`timescale 1ns/100ps
module pd_wake_sampler
  import ext_irq_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = STARTUP_CYCLES_DEF
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  wake_if.waker     wk
);

  typedef enum logic [1:0] {W_IDLE, W_ONE, W_START, W_AWAKE} wake_state_e;

  typedef struct packed {
    wake_state_e              st;
    logic [WDT_CNT_W-1:0]     div;
    logic [STARTUP_CNT_W-1:0] cnt;
    logic                     wake;
  } waker_s;

  localparam logic [WDT_CNT_W-1:0] DIV_LAST = WDT_CNT_W'(WDT_TICK_CYCLES - 1);
  localparam logic [STARTUP_CNT_W-1:0] SU_LAST = STARTUP_CNT_W'(STARTUP_CYCLES - 1);

  waker_s st_reg;
  waker_s st_next;
  logic   tick;

  // The watchdog oscillator is modelled as a one-cycle enable every period.
  assign tick    = (st_reg.div == DIV_LAST);
  assign wk.wake = st_reg.wake;
  assign wk.busy = (st_reg.st != W_IDLE);

  always_comb begin
    st_next     = st_reg;
    st_next.div = tick ? '0 : st_reg.div + WDT_CNT_W'(1);
    unique case (st_reg.st)
      W_IDLE: begin
        st_next.wake = 1'b0;
        if (wk.pd && tick && wk.lvl_low) begin
          st_next.st = W_ONE;
        end
      end
      W_ONE: begin
        if (!wk.pd) begin
          st_next.st = W_IDLE;
        end else if (tick) begin
          st_next.st   = wk.lvl_low ? W_START : W_IDLE;
          st_next.wake = wk.lvl_low;
          st_next.cnt  = '0;
        end
      end
      W_START: begin
        // The level may vanish here; wake-up still completes unless power-down ends.
        if (!wk.pd) begin
          st_next.st   = W_IDLE;
          st_next.wake = 1'b0;
        end else if (st_reg.cnt == SU_LAST) begin
          st_next.st = W_AWAKE;
        end else begin
          st_next.cnt = st_reg.cnt + STARTUP_CNT_W'(1);
        end
      end
      W_AWAKE: begin
        if (!wk.pd) begin
          st_next.st   = W_IDLE;
          st_next.wake = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg <= '{st: W_IDLE, div: '0, cnt: '0, wake: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

// ---- logic/ext_pin_irq_unit.sv ----
// External pin interrupt unit: sense decode, flags, masking and wake-up.
`timescale 1ns/100ps
module ext_pin_irq_unit
  import ext_irq_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = STARTUP_CYCLES_DEF
) (
  input  wire logic                clk_i,
  input  wire logic                rstn_i,
  input  wire logic [NUM_PINS-1:0] ext_irq_pins_i,
  input  wire logic                io_clk_run_i,
  input  wire logic                power_down_i,
  input  wire logic                compat_mode_i,
  input  wire logic                ack_i,
  input  wire logic [2:0]          ack_pin_i,
  input  wire logic [ADDR_W-1:0]   addr_i,
  input  wire logic [DATA_W-1:0]   wdata_i,
  input  wire logic                we_i,
  input  wire logic                re_i,
  output logic      [DATA_W-1:0]   rdata_o,
  output logic                     irq_o,
  output logic      [NUM_PINS-1:0] irq_req_o,
  output logic                     wake_o
);

  typedef struct packed {
    logic [NUM_PINS-1:0]  sync1;
    logic [NUM_PINS-1:0]  sync2;
    logic [NUM_PINS-1:0]  prev;
    logic [DATA_W-1:0]    lower_sense_ctrl;
    logic [DATA_W-1:0]    upper_sense_ctrl;
    logic [NUM_PINS-1:0]  ext_irq_mask;
    logic [NUM_PINS-1:0]  ext_irq_flags;
    logic [NUM_LOWER-1:0] capture;
    logic                 global_irq_enable;
    logic [DATA_W-1:0]    rdata;
    logic                 irq;
    logic [NUM_PINS-1:0]  irq_req;
    logic                 wake;
  } unit_s;

  unit_s st_reg;
  unit_s st_next;

  logic [NUM_PINS-1:0]  level_mode;
  logic [NUM_PINS-1:0]  edge_hit;
  logic [NUM_PINS-1:0]  level_low;
  logic [NUM_PINS-1:0]  flag_clr;
  logic [NUM_PINS-1:0]  ack_clr;
  logic [NUM_PINS-1:0]  wr_clr;
  logic                 wr_flags;
  logic                 lvl_wake_any;
  logic                 edge_wake_any;

  wake_if wk ();

  pd_wake_sampler #(
    .STARTUP_CYCLES (STARTUP_CYCLES)
  ) u_waker (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .wk     (wk)
  );

  // Per-pin sense decode. The pin level is the pad itself, so a pin that the
  // port drives as an output still triggers, which gives a software interrupt.
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    logic [1:0] sel;
    logic       rise;
    logic       fall;
    assign rise         = st_reg.sync2[i] & ~st_reg.prev[i];
    assign fall         = ~st_reg.sync2[i] & st_reg.prev[i];
    assign level_low[i] = ~st_reg.sync2[i];
    if (i < NUM_LOWER) begin : g_lower
      assign sel = st_reg.lower_sense_ctrl[2*i +: 2];
      // Lower edges ignore the I/O clock state and the reserved code is inert.
      always_comb begin
        unique case (sel)
          SENSE_LOW:  edge_hit[i] = 1'b0;
          SENSE_ANY:  edge_hit[i] = 1'b0;
          SENSE_FALL: edge_hit[i] = fall;
          SENSE_RISE: edge_hit[i] = rise;
        endcase
      end
    end else begin : g_upper
      assign sel = st_reg.upper_sense_ctrl[2*(i-NUM_LOWER) +: 2];
      always_comb begin
        unique case (sel)
          SENSE_LOW:  edge_hit[i] = 1'b0;
          SENSE_ANY:  edge_hit[i] = io_clk_run_i & (rise | fall);
          SENSE_FALL: edge_hit[i] = io_clk_run_i & fall;
          SENSE_RISE: edge_hit[i] = io_clk_run_i & rise;
        endcase
      end
    end
    assign level_mode[i] = (sel == SENSE_LOW);
    assign ack_clr[i]    = ack_i && (ack_pin_i == 3'(i));
    assign wr_clr[i]     = wr_flags && wdata_i[i];
    assign flag_clr[i]   = ack_clr[i] | wr_clr[i];
  end

  assign wr_flags = we_i && (addr_i == FLAGS_OFS);

  // Level wake candidates: enabled level pins held low during power-down.
  assign lvl_wake_any  = |(level_mode & level_low & st_reg.ext_irq_mask);
  assign edge_wake_any = |(st_reg.ext_irq_flags[NUM_LOWER-1:0]
                           & st_reg.ext_irq_mask[NUM_LOWER-1:0]);
  assign wk.pd         = power_down_i;
  assign wk.lvl_low    = lvl_wake_any;

  assign rdata_o   = st_reg.rdata;
  assign irq_o     = st_reg.irq;
  assign irq_req_o = st_reg.irq_req;
  assign wake_o    = st_reg.wake;

  always_comb begin
    logic [NUM_PINS-1:0] pend;
    logic [NUM_PINS-1:0] lvl_req;
    logic [NUM_PINS-1:0] flags_set;
    pend      = '0;
    lvl_req   = '0;
    flags_set = '0;
    st_next   = st_reg;

    // Two-stage synchroniser; only the second stage feeds any logic.
    st_next.sync1 = ext_irq_pins_i;
    st_next.sync2 = st_reg.sync1;
    st_next.prev  = st_reg.sync2;

    // Lower edges are caught first and reach the flag one cycle later. Two
    // sample stages at 8 ns keep every pulse wider than the minimum width.
    for (int i = 0; i < NUM_LOWER; i++) begin
      if (edge_hit[i]) begin
        st_next.capture[i] = 1'b1;
      end else if (flag_clr[i]) begin
        st_next.capture[i] = 1'b0;
      end
      flags_set[i] = st_reg.capture[i];
    end
    for (int i = NUM_LOWER; i < NUM_PINS; i++) begin
      flags_set[i] = edge_hit[i];
    end

    // Set beats clear on upper pins; on a lower pin clear wins unless a new edge comes that cycle; a level-sensed pin keeps its flag at zero.
    for (int i = 0; i < NUM_PINS; i++) begin
      if (level_mode[i]) begin
        st_next.ext_irq_flags[i] = 1'b0;
      end else if (flags_set[i] && !(i < NUM_LOWER && flag_clr[i])) begin
        st_next.ext_irq_flags[i] = 1'b1;
      end else if (flags_set[i]) begin
        st_next.ext_irq_flags[i] = edge_hit[i];
      end else if (flag_clr[i]) begin
        st_next.ext_irq_flags[i] = 1'b0;
      end
    end

    // Level requests are held back in power-down; the waker decides there,
    // and a level gone by the end of start-up simply never requests.
    lvl_req = level_mode & level_low & {NUM_PINS{~power_down_i}};
    pend    = (st_reg.ext_irq_flags | lvl_req) & st_reg.ext_irq_mask;
    st_next.irq_req = pend & {NUM_PINS{st_reg.global_irq_enable}};
    st_next.irq     = |st_next.irq_req;

    // Wake on a confirmed level or on a pending enabled lower edge.
    st_next.wake = wk.wake | (power_down_i & edge_wake_any);

    // Register writes. Sense changes are applied as written, so a change into level
    // sensing with the pin low requests at once; software is expected to mask first.
    if (we_i) begin
      unique case (addr_i)
        LOWER_SENSE_OFS: begin
          if (!compat_mode_i) begin
            st_next.lower_sense_ctrl = wdata_i;
          end
        end
        UPPER_SENSE_OFS: st_next.upper_sense_ctrl = wdata_i;
        MASK_OFS:        st_next.ext_irq_mask = wdata_i;
        GIE_OFS:         st_next.global_irq_enable = wdata_i[GIE_BIT];
        default: begin
        end
      endcase
    end

    // Read data stands in the cycle after the strobe only.
    st_next.rdata = '0;
    if (re_i) begin
      unique case (addr_i)
        LOWER_SENSE_OFS: begin
          st_next.rdata = compat_mode_i ? '0 : st_reg.lower_sense_ctrl;
        end
        UPPER_SENSE_OFS: st_next.rdata = st_reg.upper_sense_ctrl;
        MASK_OFS:        st_next.rdata = st_reg.ext_irq_mask;
        FLAGS_OFS:       st_next.rdata = st_reg.ext_irq_flags;
        GIE_OFS:         st_next.rdata[GIE_BIT] = st_reg.global_irq_enable;
        PIN_LEVEL_OFS:   st_next.rdata = st_reg.sync2;
        WAKE_STAT_OFS:   st_next.rdata[WAKE_BIT] = st_reg.wake;
        default:         st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg <= '{
        sync1:             '1,
        sync2:             '1,
        prev:              '1,
        lower_sense_ctrl:  LOWER_SENSE_RST,
        upper_sense_ctrl:  UPPER_SENSE_RST,
        ext_irq_mask:      MASK_RST,
        ext_irq_flags:     FLAGS_RST,
        capture:           '0,
        global_irq_enable: GIE_RST,
        rdata:             '0,
        irq:               1'b0,
        irq_req:           '0,
        wake:              1'b0
      };
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

// ---- bench/ext_irq_checker_assertions.sv ----
// Port-level assertions for the external pin interrupt unit.
`timescale 1ns/100ps
module ext_irq_checker
  import ext_irq_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = STARTUP_CYCLES_DEF
) (
  input wire logic                clk_i,
  input wire logic                rstn_i,
  input wire logic [NUM_PINS-1:0] ext_irq_pins_i,
  input wire logic                io_clk_run_i,
  input wire logic                power_down_i,
  input wire logic                compat_mode_i,
  input wire logic                ack_i,
  input wire logic [2:0]          ack_pin_i,
  input wire logic [ADDR_W-1:0]   addr_i,
  input wire logic [DATA_W-1:0]   wdata_i,
  input wire logic                we_i,
  input wire logic                re_i,
  input wire logic [DATA_W-1:0]   rdata_o,
  input wire logic                irq_o,
  input wire logic [NUM_PINS-1:0] irq_req_o,
  input wire logic                wake_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  irq_or_a: assert property (irq_o == |irq_req_o)
    else $error("irq output differs from the request OR");
  idle_read_a: assert property (!re_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  unmapped_read_a: assert property (re_i && addr_i == 3'h7 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  compat_read_a: assert property (
    compat_mode_i && re_i && addr_i == LOWER_SENSE_OFS |=> rdata_o == 8'h00)
    else $error("lower sense visible in compat mode");
  gie_off_a: assert property (
    we_i && addr_i == GIE_OFS && !wdata_i[GIE_BIT] ##1 !we_i [*2] |-> irq_req_o == 8'h00)
    else $error("request without global enable");
  mask_off_a: assert property (
    we_i && addr_i == MASK_OFS && wdata_i == 8'h00 ##1 !we_i [*2] |-> irq_req_o == 8'h00)
    else $error("request with all pins masked");
  wake_drop_a: assert property (!power_down_i [*3] |-> !wake_o)
    else $error("wake held outside power-down");
  pin_level_a: assert property (
    $stable(ext_irq_pins_i) [*4] ##0 re_i && addr_i == PIN_LEVEL_OFS
    |=> rdata_o == $past(ext_irq_pins_i))
    else $error("pin level read wrong");
endmodule

bind ext_pin_irq_unit ext_irq_checker #(.STARTUP_CYCLES(STARTUP_CYCLES)) chk (
  .clk_i(clk_i), .rstn_i(rstn_i), .ext_irq_pins_i(ext_irq_pins_i),
  .io_clk_run_i(io_clk_run_i), .power_down_i(power_down_i), .compat_mode_i(compat_mode_i),
  .ack_i(ack_i), .ack_pin_i(ack_pin_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
  .re_i(re_i), .rdata_o(rdata_o), .irq_o(irq_o), .irq_req_o(irq_req_o), .wake_o(wake_o)
);

// ---- bench/pin_board.sv ----
// Board model that drives the eight external interrupt pins.
`timescale 1ns/100ps
module pin_board
  import ext_irq_pkg::*;
(
  input  wire logic                clk_i,
  output logic      [NUM_PINS-1:0] ext_irq_pins_o
);
  initial begin
    ext_irq_pins_o = 8'hff;
  end

  // Levels change only after a clock edge and then hold, so a low outlasts the instruction.
  task automatic set_pin(input int p, input logic lvl);
    @(posedge clk_i);
    ext_irq_pins_o[p] <= lvl;
  endtask

  // Callers keep n at or above the minimum pulse width in cycles.
  task automatic pulse_pin(input int p, input logic lvl, input int n);
    set_pin(p, lvl);
    repeat (n) @(posedge clk_i);
    ext_irq_pins_o[p] <= !lvl;
  endtask
endmodule

// ---- bench/test_ext_pin_irq_unit.sv ----
// Self-checking bench for the external pin interrupt unit.
`timescale 1ns/100ps
module test_ext_pin_irq_unit
  import ext_irq_pkg::*;
();
  typedef struct packed {
    logic [2:0] pin;
    logic [1:0] code;
    logic       start;
    logic       fin;
    logic       run;
    logic       exp;
  } row_s;
  // Pin, sense code, start level, end level, I/O clock running, request expected.
  row_s rows [13] = '{'{0, 0, 1, 0, 1, 1}, '{0, 1, 1, 0, 1, 0}, '{0, 1, 0, 1, 1, 0},
    '{0, 2, 1, 0, 1, 1}, '{0, 2, 0, 1, 1, 0}, '{0, 3, 0, 1, 1, 1}, '{0, 3, 0, 1, 0, 1},
    '{3, 3, 0, 1, 1, 1}, '{4, 3, 0, 1, 1, 1}, '{4, 3, 0, 1, 0, 0}, '{4, 2, 1, 0, 0, 0},
    '{4, 1, 0, 1, 1, 1}, '{4, 0, 1, 0, 0, 1}};
  logic                clk_i         = 1'b0;
  logic                rstn_i        = 1'b0;
  logic                io_clk_run_i  = 1'b1;
  logic                power_down_i  = 1'b0;
  logic                compat_mode_i = 1'b0;
  logic                ack_i         = 1'b0;
  logic [2:0]          ack_pin_i     = 3'h0;
  logic [ADDR_W-1:0]   addr_i        = 3'h0;
  logic [DATA_W-1:0]   wdata_i       = 8'h00;
  logic                we_i          = 1'b0;
  logic                re_i          = 1'b0;
  logic [DATA_W-1:0]   rdata_o;
  logic                irq_o;
  logic                wake_o;
  logic [NUM_PINS-1:0] irq_req_o;
  logic [NUM_PINS-1:0] pins;
  int                  miscompares   = 0;
  int                  compares      = 0;

  pin_board board (.clk_i(clk_i), .ext_irq_pins_o(pins));
  ext_pin_irq_unit #(.STARTUP_CYCLES(8)) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .ext_irq_pins_i(pins), .io_clk_run_i(io_clk_run_i),
    .power_down_i(power_down_i), .compat_mode_i(compat_mode_i), .ack_i(ack_i),
    .ack_pin_i(ack_pin_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
    .rdata_o(rdata_o), .irq_o(irq_o), .irq_req_o(irq_req_o), .wake_o(wake_o));

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    we_i    <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask

  task automatic chk_rd(input string name, input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    re_i   <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1 check(name, rdata_o, exp);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    finish_test();
  end

  initial begin
    row_s r;
    int   n;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      chk_rd("reset reg", a[2:0], (a == 5) ? 8'hff : 8'h00);
    end
    foreach (rows[i]) begin
      r = rows[i];
      @(posedge clk_i);
      io_clk_run_i <= r.run;
      wr(MASK_OFS, 8'h00);
      board.set_pin(r.pin, r.start);
      wait_cyc(4);
      if (r.pin < 3'h4) begin
        wr(LOWER_SENSE_OFS, 8'(r.code) << (2 * r.pin));
      end else begin
        wr(UPPER_SENSE_OFS, 8'(r.code) << (2 * (r.pin - 4)));
      end
      wr(FLAGS_OFS, 8'hff);
      wr(MASK_OFS, 8'h01 << r.pin);
      wr(GIE_OFS, 8'h01);
      board.set_pin(r.pin, r.fin);
      wait_cyc(8);
      check("req", irq_req_o[r.pin], r.exp);
      check("irq", irq_o, r.exp);
      chk_rd("flag", FLAGS_OFS, 8'(r.exp && r.code != 2'h0) << r.pin);
      board.set_pin(r.pin, 1'b1);
    end
    io_clk_run_i <= 1'b1;
    wr(MASK_OFS, 8'h00);
    wr(LOWER_SENSE_OFS, 8'h0c);
    wr(FLAGS_OFS, 8'hff);
    wr(MASK_OFS, 8'h02);
    board.pulse_pin(1, 1'b0, MIN_PULSE_CYCLES);
    wait_cyc(8);
    check("pulse", irq_req_o[1], 1'b1);
    wr(GIE_OFS, 8'h00);
    wait_cyc(2);
    check("gie off", irq_req_o[1], 1'b0);
    wr(GIE_OFS, 8'h01);
    wait_cyc(2);
    check("gie on", irq_req_o[1], 1'b1);
    @(posedge clk_i);
    ack_pin_i <= 3'h1;
    ack_i     <= 1'b1;
    @(posedge clk_i);
    ack_i <= 1'b0;
    wait_cyc(3);
    check("ack", irq_req_o[1], 1'b0);
    board.pulse_pin(1, 1'b0, MIN_PULSE_CYCLES);
    wait_cyc(8);
    check("pulse again", irq_req_o[1], 1'b1);
    wr(FLAGS_OFS, 8'h02);
    wait_cyc(2);
    check("write one", irq_req_o[1], 1'b0);
    @(posedge clk_i);
    compat_mode_i <= 1'b1;
    wr(LOWER_SENSE_OFS, 8'hff);
    chk_rd("compat", LOWER_SENSE_OFS, 8'h00);
    @(posedge clk_i);
    compat_mode_i <= 1'b0;
    chk_rd("sense kept", LOWER_SENSE_OFS, 8'h0c);
    wr(MASK_OFS, 8'h00);
    wr(LOWER_SENSE_OFS, 8'h00);
    wr(MASK_OFS, 8'h01);
    power_down_i <= 1'b1;
    io_clk_run_i <= 1'b0;
    // A low that spans exactly one watchdog tick period is seen by one sample only.
    board.pulse_pin(0, 1'b0, WDT_TICK_CYCLES);
    wait_cyc(300);
    check("glitch", wake_o, 1'b0);
    board.set_pin(0, 1'b0);
    for (n = 0; n < 400 && wake_o !== 1'b1; n++) begin
      wait_cyc(1);
    end
    check("wake", wake_o, 1'b1);
    board.set_pin(0, 1'b1);
    wait_cyc(20);
    check("wake hold", wake_o, 1'b1);
    chk_rd("wake stat", WAKE_STAT_OFS, 8'h01);
    @(posedge clk_i);
    power_down_i <= 1'b0;
    wait_cyc(4);
    check("wake end", wake_o, 1'b0);
    check("no level irq", irq_o, 1'b0);
    wr(LOWER_SENSE_OFS, 8'hff);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    chk_rd("reset sense", LOWER_SENSE_OFS, LOWER_SENSE_RST);
    check("reset wake", wake_o, 1'b0);
    finish_test();
  end
endmodule
